// ### sbr_asserts.sv
// Concurrent checks on the replier link and its bus control lines
`timescale 1ns/1ps
module sbr_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Link signals
	input wire logic select,
	input wire logic broadcast,
	input wire logic host_ready,
	input wire logic err_clear,
	input wire logic other_agent_ready,
	input wire logic last_transfer,
	input wire logic transceiver_direction,
	input wire logic host_error_interrupt,
	// Bus control lines
	input wire logic [9:0] SC_IN,
	input wire logic [7:4] SC_OUT,
	input wire logic CTRL_UPPER_NIBBLE_DRIVE_EN,
	input wire logic CTRL_LOWER_NIBBLE_DRIVE_EN
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	sel_hold_a: assert property ($rose(select) |=> select)
		else $error("select held for one cycle only");
	ready_late_a: assert property (host_ready |-> $past(select))
		else $error("ready before second select cycle");
	ready_pulse_a: assert property (host_ready |=> !host_ready)
		else $error("ready longer than one clock");
	upper_drive_a: assert property ($rose(select) |=>
		CTRL_UPPER_NIBBLE_DRIVE_EN)
		else $error("upper drivers not enabled on select");
	idle_dir_a: assert property (!select |-> !transceiver_direction)
		else $error("transceivers turned while unselected");
	ack_answer_a: assert property (host_ready && !broadcast |=> SC_OUT[4])
		else $error("no acknowledge after ready");
	ack_hold_a: assert property (SC_OUT[4] && !SC_IN[3] |=> SC_OUT[4])
		else $error("acknowledge dropped before answer");
	ack_drop_a: assert property (SC_OUT[4] && SC_IN[3] |=> !SC_OUT[4])
		else $error("acknowledge kept after answer");
	bcast_quiet_a: assert property (broadcast |->
		!SC_OUT[4] && !CTRL_LOWER_NIBBLE_DRIVE_EN)
		else $error("replier drove handshake in broadcast");
	bcast_sel_a: assert property ($rose(broadcast) |-> $rose(select))
		else $error("broadcast not raised with select");
	other_rdy_a: assert property (select && $past(select) |->
		other_agent_ready == $past(SC_IN[3]))
		else $error("other ready is not delayed answer line");
	last_out_a: assert property (select && $past(select) |->
		last_transfer == $past(SC_IN[2]))
		else $error("last transfer is not delayed end line");
	clear_int_a: assert property (err_clear |=>
		!host_error_interrupt && !err_clear)
		else $error("interrupt not cleared by clear pulse");
	int_gap_a: assert property ($fell(host_error_interrupt) |=>
		!host_error_interrupt)
		else $error("interrupt gap shorter than two clocks");

	cover property (SC_OUT[4] && SC_IN[3]);
	cover property (select && broadcast);
	cover property ($rose(host_error_interrupt));
	cover property ($fell(host_error_interrupt) ##2 host_error_interrupt);
endmodule

// ### sbr_device.sv
// Replier handshake, parity and protocol checks, host error reporting
`timescale 1ns/1ps
module sbr_device
	import sbr_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// On-board host link
	sbr_if.dev LNK,
	// System bus control lines, 1 = asserted
	input wire logic [9:0] SC_IN,
	input wire logic [1:0] SC_PAR_IN,
	output logic [7:4] SC_OUT,
	output logic CTRL_UPPER_NIBBLE_DRIVE_EN,
	output logic CTRL_LOWER_NIBBLE_DRIVE_EN,
	// Address and data parity qualification
	input wire logic [1:0] ADDR_PIN_LOW,
	input wire logic [3:0] BYTE_PARITY_ERROR_IN,
	// Bus status
	input wire logic BUS_ERROR_IN,
	input wire logic TIMEOUT_IN,
	input wire logic BUS_OWNER_IN,
	output logic BUS_ERROR_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Request phase decode
	sbr_dev_st_t st_q, st_d;
	logic [1:0] width_q, space_q, addr_q;
	logic write_q, viol_q, reply_q, bcast_q;
	logic upper_en_q, dir_q, sc4_q, bus_err_q, ordy_q, last_q;
	logic [2:0] code_q;

	wire req_ph = SC_IN[SC_REQ];
	wire [1:0] rq_w = SC_IN[RQ_WIDTH_LSB +: 2];
	wire [1:0] rq_s = SC_IN[RQ_SPACE_LSB +: 2];
	wire rq_wr = SC_IN[RQ_WRITE];
	wire rq_seq = SC_IN[RQ_SEQ];
	wire [1:0] al = ADDR_PIN_LOW;
	wire rq_mio = (rq_s == SP_MEM) || (rq_s == SP_IO);
	wire viol_msg = (rq_s == SP_MSG) && (rq_w == W8 || rq_w == W24 ||
		!rq_wr);
	wire viol_ic = (rq_s == SP_IC) && (rq_w != W8 || (|al) || rq_seq);
	wire viol_mio = rq_mio && ((rq_w == W16 && (&al)) ||
		(rq_w == W24 && al[1]) || (rq_w == W32 && (|al)) ||
		(rq_seq && (|al)));
	wire viol = viol_msg || viol_ic || viol_mio;

	wire eoc = reply_q && SC_IN[SC_EOT] && SC_IN[SC_RQ_RDY] &&
		SC_IN[SC_RP_RDY];
	wire [2:0] sc_err = SC_IN[SC_ERR_LSB +: 3];
	wire active = (st_q != D_IDLE);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			width_q <= W8;
			space_q <= SP_MEM;
			addr_q <= 2'h0;
			write_q <= 1'b0;
			viol_q <= 1'b0;
			reply_q <= 1'b0;
		end else begin
			if (req_ph) begin
				width_q <= rq_w;
				space_q <= rq_s;
				addr_q <= al;
				write_q <= rq_wr;
				viol_q <= viol;
			end
			reply_q <= req_ph || (reply_q && !eoc);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Replier handshake
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			D_IDLE: begin
				if (LNK.select) begin
					st_d = D_SEL;
				end
			end
			D_SEL: begin
				if (bcast_q) begin
					if (eoc) begin
						st_d = D_DONE;
					end
				end else if (LNK.host_ready) begin
					st_d = D_HS;
				end
			end
			D_HS: begin
				if (SC_IN[SC_RQ_RDY]) begin
					st_d = SC_IN[SC_EOT] ? D_DONE : D_SEL;
				end
			end
			D_DONE: begin
				if (!LNK.select) begin
					st_d = D_IDLE;
				end
			end
		endcase
	end

	wire [2:0] reply_code = viol_q ? AE_NOT_UND : LNK.agent_error;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= D_IDLE;
			bcast_q <= 1'b0;
			upper_en_q <= 1'b0;
			dir_q <= 1'b0;
			sc4_q <= 1'b0;
			code_q <= AE_NONE;
		end else begin
			st_q <= st_d;
			if (st_q == D_IDLE && LNK.select) begin
				bcast_q <= LNK.broadcast;
				upper_en_q <= 1'b1;
				dir_q <= !write_q;
			end
			if (st_d == D_DONE || st_d == D_IDLE) begin
				upper_en_q <= 1'b0;
				dir_q <= 1'b0;
			end
			if (st_q == D_SEL && st_d == D_HS) begin
				sc4_q <= 1'b1;
				code_q <= reply_code;
			end else if (st_q == D_HS && st_d != D_HS) begin
				sc4_q <= 1'b0;
				code_q <= AE_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parity and reply-phase checks
	wire sc_par_bad = (^{SC_IN[4:0], SC_PAR_IN[0]}) ||
		(^{SC_IN[9:5], SC_PAR_IN[1]});
	wire [3:0] rq_lanes = (rq_s == SP_MEM) ? 4'hF : 4'h3;
	wire rq_par_bad = req_ph && (|(BYTE_PARITY_ERROR_IN & rq_lanes));
	wire rp_clean = SC_IN[SC_RQ_RDY] && SC_IN[SC_RP_RDY] && !(|sc_err);
	wire rp_par_bad = reply_q && active && write_q && rp_clean &&
		(|(BYTE_PARITY_ERROR_IN &
		sbr_lanes(width_q, space_q, addr_q)));
	wire rp_viol = reply_q && ((SC_IN[SC_EOT] && !SC_IN[SC_RQ_RDY]) ||
		((|sc_err) && !SC_IN[SC_RP_RDY]));

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bus_err_q <= 1'b0;
			ordy_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			bus_err_q <= sc_par_bad || rq_par_bad || rp_par_bad ||
				rp_viol;
			ordy_q <= active && SC_IN[SC_RQ_RDY];
			last_q <= active && SC_IN[SC_EOT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host error reporting
	logic own_d_q, msg_win_q, eoc_d_q, pend_q, pend_d, held_q, int_q;
	logic [4:0] err_q, held_err_q;
	logic [1:0] gap_q, gap_d;

	wire msg_req = req_ph && (rq_s == SP_MSG);
	wire bus_seen = BUS_ERROR_IN || bus_err_q;
	wire agent_seen = SC_IN[SC_RP_RDY] && (|sc_err);
	wire err_win = own_d_q && !msg_win_q;
	wire ev = err_win && (bus_seen || TIMEOUT_IN || agent_seen);
	wire [4:0] snap = {bus_seen, TIMEOUT_IN, sc_err};
	wire clr = LNK.err_clear && pend_q;
	wire reload = clr && (held_q || (ev && bus_seen) || ev);

	always_comb begin
		pend_d = pend_q;
		gap_d = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
		if (reload) begin
			gap_d = GAP_CYC;
		end else if (clr) begin
			pend_d = 1'b0;
		end else if (ev) begin
			pend_d = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			own_d_q <= 1'b0;
			msg_win_q <= 1'b0;
			eoc_d_q <= 1'b0;
			pend_q <= 1'b0;
			held_q <= 1'b0;
			err_q <= ER_RST;
			held_err_q <= ER_RST;
			gap_q <= 2'h0;
			int_q <= 1'b0;
		end else begin
			own_d_q <= BUS_OWNER_IN;
			eoc_d_q <= eoc;
			msg_win_q <= msg_req || (msg_win_q && !eoc_d_q);
			pend_q <= pend_d;
			gap_q <= gap_d;
			int_q <= pend_d && (gap_d == 2'h0);
			if (reload) begin
				err_q <= held_q ? held_err_q : snap;
				held_q <= held_q && ev && bus_seen;
				held_err_q <= snap;
			end else if (ev && !pend_q) begin
				err_q <= snap;
			end else if (ev && pend_q && bus_seen && !held_q) begin
				held_q <= 1'b1;
				held_err_q <= snap;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign SC_OUT = {~code_q, sc4_q};
	assign CTRL_UPPER_NIBBLE_DRIVE_EN = upper_en_q;
	assign CTRL_LOWER_NIBBLE_DRIVE_EN = 1'b0;
	assign BUS_ERROR_OUT = bus_err_q;
	assign LNK.other_agent_ready = ordy_q;
	assign LNK.last_transfer = last_q;
	assign LNK.transceiver_direction = dir_q;
	assign LNK.host_error_interrupt = int_q;
	assign LNK.error_reg = err_q;

endmodule

// ### sbr_host.sv
// On-board host logic: replier sequencing under AXI4-Lite control
`timescale 1ns/1ps
module sbr_host
	import sbr_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Device link
	sbr_if.host LNK,
	// AXI4-Lite write
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);

	////////////////////////////////////////////////////////////////////////
	// Write channel
	logic aw_have_q, w_have_q, awrdy_q, wrdy_q, bvalid_q, clr_q;
	logic [7:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic [4:0] ctrl_q;

	wire aw_take = AWVALID && awrdy_q;
	wire w_take = WVALID && wrdy_q;
	wire aw_h = aw_have_q || aw_take;
	wire w_h = w_have_q || w_take;
	wire wr_go = aw_h && w_h && !bvalid_q;
	wire [7:0] wa = aw_have_q ? aw_addr_q : AWADDR;
	wire [31:0] wd = w_have_q ? wdata_q : WDATA;
	wire [3:0] ws = w_have_q ? wstrb_q : WSTRB;
	wire wa_ok = (wa == REG_CTRL) || (wa == REG_STATUS) ||
		(wa == REG_ERROR) || (wa == REG_ERR_CLR);
	wire bv_n = wr_go || (bvalid_q && !BREADY);
	wire aw_n = aw_h && !wr_go;
	wire w_n = w_h && !wr_go;
	wire ctrl_wr = wr_go && (wa == REG_CTRL) && ws[0];
	sbr_host_st_t st_q;
	wire go = ctrl_wr && wd[CTRL_GO] && (st_q == H_IDLE);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awrdy_q <= 1'b0;
			wrdy_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			ctrl_q <= CTRL_RST;
			clr_q <= 1'b0;
		end else begin
			aw_have_q <= aw_n;
			w_have_q <= w_n;
			awrdy_q <= !aw_n && !bv_n;
			wrdy_q <= !w_n && !bv_n;
			bvalid_q <= bv_n;
			if (aw_take) begin
				aw_addr_q <= AWADDR;
			end
			if (w_take) begin
				wdata_q <= WDATA;
				wstrb_q <= WSTRB;
			end
			if (wr_go) begin
				bresp_q <= wa_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (ctrl_wr) begin
				ctrl_q <= wd[4:0];
			end
			clr_q <= wr_go && (wa == REG_ERR_CLR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	logic arrdy_q, rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic sel_q, bc_q, rdy_q;
	logic [2:0] ae_q;

	wire ar_take = ARVALID && arrdy_q;
	wire rv_n = ar_take || (rvalid_q && !RREADY);
	wire [31:0] status = {27'h0, LNK.host_error_interrupt,
		LNK.transceiver_direction, LNK.last_transfer,
		LNK.other_agent_ready, (st_q != H_IDLE)};
	wire ra_ok = (ARADDR == REG_CTRL) || (ARADDR == REG_STATUS) ||
		(ARADDR == REG_ERROR) || (ARADDR == REG_ERR_CLR);
	wire [31:0] rmux = (ARADDR == REG_CTRL) ? {27'h0, ctrl_q} :
		(ARADDR == REG_STATUS) ? status :
		(ARADDR == REG_ERROR) ? {27'h0, LNK.error_reg} : 32'h0000_0000;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			arrdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else begin
			arrdy_q <= !rv_n;
			rvalid_q <= rv_n;
			if (ar_take) begin
				rdata_q <= rmux;
				rresp_q <= ra_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Replier sequencing toward the device
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= H_IDLE;
			sel_q <= 1'b0;
			bc_q <= 1'b0;
			rdy_q <= 1'b0;
			ae_q <= AE_NONE;
		end else begin
			rdy_q <= 1'b0;
			unique case (st_q)
				H_IDLE: begin
					if (go) begin
						sel_q <= 1'b1;
						bc_q <= wd[CTRL_BCAST];
						ae_q <= wd[CTRL_AE_LSB +: 3];
						st_q <= H_SEL;
					end
				end
				H_SEL: begin
					rdy_q <= !bc_q;
					st_q <= H_WAIT;
				end
				H_WAIT: begin
					if (LNK.last_transfer) begin
						sel_q <= 1'b0;
						bc_q <= 1'b0;
						ae_q <= AE_NONE;
						st_q <= H_IDLE;
					end else if (LNK.other_agent_ready && !bc_q) begin
						rdy_q <= 1'b1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign AWREADY = awrdy_q;
	assign WREADY = wrdy_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = arrdy_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign LNK.select = sel_q;
	assign LNK.broadcast = bc_q;
	assign LNK.host_ready = rdy_q;
	assign LNK.agent_error = ae_q;
	assign LNK.err_clear = clr_q;

endmodule

// ### sbr_if.sv
// Link between the replier device and its on-board host logic
`timescale 1ns/1ps
interface sbr_if;
	logic select;
	logic broadcast;
	logic host_ready;
	logic [2:0] agent_error;
	logic err_clear;
	logic other_agent_ready;
	logic last_transfer;
	logic transceiver_direction;
	logic host_error_interrupt;
	logic [4:0] error_reg;

	modport dev (
		input select, broadcast, host_ready, agent_error, err_clear,
		output other_agent_ready, last_transfer, transceiver_direction,
		output host_error_interrupt, error_reg
	);

	modport host (
		output select, broadcast, host_ready, agent_error, err_clear,
		input other_agent_ready, last_transfer, transceiver_direction,
		input host_error_interrupt, error_reg
	);
endinterface

// ### sbr_pkg.sv
// Constants and types shared by the replier device end and the host end
// How it works
// - Select enables upper drivers; reads turn transceivers.
// - Host holds select two cycles, ready later.
// - Each ready drives SC4 until SC3 answers.
// - Host pulses ready one clock per transfer.
// - Host holds agent error until end-of-transfer.
// - Flag bad message and interconnect requests.
// - Flag misaligned memory and I/O requests.
// - Violation forces not-understood; driven at ready.
// - Agent error codes on SC7..SC5 per table.
// - Delayed SC3 and SC2 go to host.
// - Host holds broadcast with select until done.
// - Broadcast: no lower drivers, ignore ready, errors.
// - Direction inward except replier read reply.
// - SC line parity checked every cycle.
// - Request phase byte parity, next-cycle bus error.
// - Reply byte parity by lanes, clean handshakes only.
// - Replier checks reply data parity on writes.
// - Reply phase SC2/SC3 and SC5-7/SC4 misuse errors.
// - Report errors in ownership window delayed one.
// - Suppress errors around message transfers.
// - Readable error register; host write clears interrupt.
// - Second bus error held; interrupt gap before reassert.
package sbr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int GAP_CLOCKS = 2;
	localparam int GAP_LESS_NS = 20;
	localparam int GAP_NS = GAP_CLOCKS * CLK_PERIOD_NS - GAP_LESS_NS;
	localparam int GAP_CYC_I = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] GAP_CYC = 2'(GAP_CYC_I < 1 ? 1 : GAP_CYC_I);

	////////////////////////////////////////////////////////////////////////
	// Control line positions (1 = line asserted)
	localparam int SC_REQ = 0;
	localparam int SC_EOT = 2;
	localparam int SC_RQ_RDY = 3;
	localparam int SC_RP_RDY = 4;
	localparam int SC_ERR_LSB = 5;
	// Request phase fields
	localparam int RQ_WIDTH_LSB = 2;
	localparam int RQ_SPACE_LSB = 4;
	localparam int RQ_WRITE = 6;
	localparam int RQ_SEQ = 7;
	localparam logic [1:0] W8 = 2'h0;
	localparam logic [1:0] W16 = 2'h1;
	localparam logic [1:0] W24 = 2'h2;
	localparam logic [1:0] W32 = 2'h3;
	localparam logic [1:0] SP_MEM = 2'h0;
	localparam logic [1:0] SP_IO = 2'h1;
	localparam logic [1:0] SP_MSG = 2'h2;
	localparam logic [1:0] SP_IC = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Agent error codes as pin levels of SC7, SC6, SC5 (1 = high)
	localparam logic [2:0] AE_DATA = 3'h2;
	localparam logic [2:0] AE_NACK = 3'h3;
	localparam logic [2:0] AE_NOT_UND = 3'h4;
	localparam logic [2:0] AE_CONT = 3'h5;
	localparam logic [2:0] AE_WIDTH = 3'h6;
	localparam logic [2:0] AE_NONE = 3'h7;
	// Error register fields
	localparam int ER_BUS = 4;
	localparam int ER_TMO = 3;
	localparam logic [4:0] ER_RST = 5'h00;

	////////////////////////////////////////////////////////////////////////
	// Software registers of the host end
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ERROR = 8'h08;
	localparam logic [7:0] REG_ERR_CLR = 8'h0C;
	localparam int CTRL_GO = 0;
	localparam int CTRL_BCAST = 1;
	localparam int CTRL_AE_LSB = 2;
	localparam logic [4:0] CTRL_RST = 5'h1C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// States
	typedef enum logic [3:0] {
		D_IDLE = 4'b0001,
		D_SEL = 4'b0010,
		D_HS = 4'b0100,
		D_DONE = 4'b1000
	} sbr_dev_st_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_SEL = 3'b010,
		H_WAIT = 3'b100
	} sbr_host_st_t;

	// Byte lanes carrying data for a width, space and low address
	function automatic logic [3:0] sbr_lanes(input logic [1:0] width,
		input logic [1:0] space, input logic [1:0] addr);
		logic [7:0] m;
		m = 8'h00;
		if (space == SP_MEM || space == SP_IO) begin
			m = 8'((8'h02 << width) - 8'h01) << addr;
		end else begin
			m = 8'h01;
		end
		return m[3:0];
	endfunction

endpackage

// ### tb.sv
// Self-checking bench: host end and replier end joined over their link
`timescale 1ns/1ps
module tb;
	import sbr_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] sc_drv = '0;
	logic [1:0] par_flip = '0;
	logic [1:0] addr_low = '0;
	logic [3:0] bpe = '0;
	logic bus_err = 1'b0;
	logic tmo = 1'b0;
	logic owner = 1'b0;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic up_en, low_en, bus_err_out;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:4] sc_out;
	wire logic [9:0] sc_in;
	int miscompares = 0;
	int samples_checked = 0;
	logic [2:0] codes [6] = '{AE_DATA, AE_NACK, AE_NOT_UND, AE_CONT,
		AE_WIDTH, AE_NONE};

	always #20 clk = ~clk;
	// Bus lines carry what the bench drives plus what the replier drives
	assign sc_in = sc_drv | {2'b00, sc_out & {4{up_en}}, 4'h0};

	sbr_if lnk();
	sbr_device i_sbr_device (.CLK(clk), .RST_B(rst_b), .LNK(lnk.dev),
		.SC_IN(sc_in), .SC_PAR_IN({^sc_in[9:5], ^sc_in[4:0]} ^ par_flip),
		.SC_OUT(sc_out), .CTRL_UPPER_NIBBLE_DRIVE_EN(up_en),
		.CTRL_LOWER_NIBBLE_DRIVE_EN(low_en), .ADDR_PIN_LOW(addr_low),
		.BYTE_PARITY_ERROR_IN(bpe), .BUS_ERROR_IN(bus_err),
		.TIMEOUT_IN(tmo), .BUS_OWNER_IN(owner), .BUS_ERROR_OUT(bus_err_out));
	sbr_host i_sbr_host (.CLK(clk), .RST_B(rst_b), .LNK(lnk.host),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready));
	sbr_asserts i_sbr_asserts (.CLK(clk), .RST_B(rst_b),
		.select(lnk.select), .broadcast(lnk.broadcast),
		.host_ready(lnk.host_ready), .err_clear(lnk.err_clear),
		.other_agent_ready(lnk.other_agent_ready),
		.last_transfer(lnk.last_transfer),
		.transceiver_direction(lnk.transceiver_direction),
		.host_error_interrupt(lnk.host_error_interrupt), .SC_IN(sc_in),
		.SC_OUT(sc_out), .CTRL_UPPER_NIBBLE_DRIVE_EN(up_en),
		.CTRL_LOWER_NIBBLE_DRIVE_EN(low_en));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Only the watchdog ends a wait that gets no answer
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		chk("rdata", d, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	// Request phase, two replier transfers, the second with end of transfer
	task automatic xfer(input logic [1:0] sp, w, ad, input logic wr, sq,
		input logic [2:0] ae, ex, input logic [3:0] pe, input logic be);
		@(posedge clk);
		sc_drv <= {2'b00, sq, wr, sp, w, 2'b01};
		addr_low <= ad;
		@(posedge clk);
		sc_drv <= '0;
		axi_wr(REG_CTRL, {27'h0, ae, 2'b01}, RESP_OKAY);
		for (int n = 0; n < 20 && sc_out[4] !== 1'b1; n++) @(negedge clk);
		chk("reply_code", {29'h0, ~ex}, {29'h0, sc_out[7:5]});
		chk("direction", 32'(!wr), 32'(lnk.transceiver_direction));
		// First handshake without end of transfer: replier waits for ready
		@(posedge clk);
		sc_drv <= 10'h008;
		@(posedge clk);
		sc_drv <= '0;
		@(negedge clk);
		chk("burst_ack_off", 32'h0, 32'(sc_out[4]));
		chk("burst_other", 32'h1, 32'(lnk.other_agent_ready));
		for (int n = 0; n < 20 && sc_out[4] !== 1'b1; n++) @(negedge clk);
		chk("burst_ack", 32'h1, 32'(sc_out[4]));
		chk("burst_code", {29'h0, ~ex}, {29'h0, sc_out[7:5]});
		@(posedge clk);
		sc_drv <= 10'h00c;
		bpe <= pe;
		@(posedge clk);
		sc_drv <= '0;
		bpe <= '0;
		@(negedge clk);
		chk("data_parity", 32'(be), 32'(bus_err_out));
		chk("last", 32'h1, 32'(lnk.last_transfer));
		chk("other_ready", 32'h1, 32'(lnk.other_agent_ready));
		repeat (4) @(posedge clk);
	endtask

	task automatic bad(input logic [1:0] sp, w, ad, input logic wr, sq);
		xfer(sp, w, ad, wr, sq, AE_DATA, AE_NOT_UND, 4'h0, 1'b0);
	endtask

	task automatic good(input logic [1:0] sp, w, ad, input logic wr, sq);
		xfer(sp, w, ad, wr, sq, AE_DATA, AE_DATA, 4'h0, 1'b0);
	endtask

	task automatic reqpar(input logic [1:0] sp, input logic [3:0] pe,
		input logic be);
		@(posedge clk);
		sc_drv <= {4'h0, sp, 4'h1};
		bpe <= pe;
		@(posedge clk);
		sc_drv <= 10'h01c;
		bpe <= '0;
		@(negedge clk);
		chk("request_parity", 32'(be), 32'(bus_err_out));
		@(posedge clk);
		sc_drv <= '0;
	endtask

	task automatic rp_err(input logic [9:0] v, input logic be);
		@(posedge clk);
		sc_drv <= 10'h001;
		@(posedge clk);
		sc_drv <= v;
		@(posedge clk);
		sc_drv <= 10'h01c;
		@(negedge clk);
		chk("reply_misuse", 32'(be), 32'(bus_err_out));
		@(posedge clk);
		sc_drv <= '0;
	endtask

	task automatic pulse_tmo;
		@(posedge clk);
		tmo <= 1'b1;
		@(posedge clk);
		tmo <= 1'b0;
	endtask

	task automatic int_is(input logic v, input int n);
		repeat (n) @(negedge clk);
		chk("interrupt", 32'(v), 32'(lnk.host_error_interrupt));
	endtask

	task automatic wait_int(input logic v);
		for (int n = 0; n < 10 && lnk.host_error_interrupt !== v; n++)
			@(negedge clk);
		chk("interrupt", 32'(v), 32'(lnk.host_error_interrupt));
	endtask

	task automatic print_verdict;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge clk);
		miscompares++;
		print_verdict;
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		axi_rd(REG_CTRL, 32'(CTRL_RST), RESP_OKAY);
		axi_rd(REG_ERROR, 32'(ER_RST), RESP_OKAY);
		axi_rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
		axi_rd(8'h10, 32'h0, RESP_SLVERR);
		axi_wr(8'h10, 32'h0, RESP_SLVERR);
		for (int i = 1; i < 4; i++) begin
			@(posedge clk);
			par_flip <= 2'(i);
			@(posedge clk);
			par_flip <= '0;
			@(negedge clk);
			chk("sc_parity", 32'h1, 32'(bus_err_out));
		end
		reqpar(SP_MEM, 4'h8, 1'b1);
		reqpar(SP_IO, 4'h8, 1'b0);
		reqpar(SP_IO, 4'h2, 1'b1);
		reqpar(SP_IC, 4'h4, 1'b0);
		rp_err(10'h004, 1'b1);
		rp_err(10'h020, 1'b1);
		rp_err(10'h018, 1'b0);
		foreach (codes[i])
			xfer(SP_MEM, W32, 2'b00, 1'b0, 1'b0, codes[i], codes[i], 4'h0,
				1'b0);
		bad(SP_MSG, W8, 2'b00, 1'b1, 1'b0);
		bad(SP_MSG, W24, 2'b00, 1'b1, 1'b0);
		bad(SP_MSG, W16, 2'b00, 1'b0, 1'b0);
		bad(SP_IC, W16, 2'b00, 1'b1, 1'b0);
		bad(SP_IC, W8, 2'b01, 1'b1, 1'b0);
		bad(SP_IC, W8, 2'b00, 1'b1, 1'b1);
		good(SP_MSG, W32, 2'b00, 1'b1, 1'b0);
		bad(SP_MEM, W16, 2'b11, 1'b1, 1'b0);
		good(SP_MEM, W16, 2'b01, 1'b1, 1'b0);
		bad(SP_IO, W24, 2'b10, 1'b0, 1'b0);
		bad(SP_MEM, W32, 2'b01, 1'b0, 1'b0);
		bad(SP_MEM, W8, 2'b01, 1'b1, 1'b1);
		xfer(SP_MEM, W16, 2'b00, 1'b1, 1'b0, AE_NONE, AE_NONE, 4'h4, 1'b0);
		xfer(SP_MEM, W16, 2'b00, 1'b1, 1'b0, AE_NONE, AE_NONE, 4'h2, 1'b1);
		xfer(SP_MEM, W16, 2'b10, 1'b1, 1'b0, AE_NONE, AE_NONE, 4'h8, 1'b1);
		xfer(SP_MEM, W32, 2'b00, 1'b0, 1'b0, AE_NONE, AE_NONE, 4'h1, 1'b0);
		// Broadcast: the requestor runs the whole handshake
		@(posedge clk);
		sc_drv <= 10'h041;
		@(posedge clk);
		sc_drv <= '0;
		axi_wr(REG_CTRL, {27'h0, AE_NONE, 2'b11}, RESP_OKAY);
		repeat (6) @(negedge clk);
		chk("bcast_ack", 32'h0, 32'(sc_out[4]));
		chk("bcast_dir", 32'h0, 32'(lnk.transceiver_direction));
		@(posedge clk);
		sc_drv <= 10'h01c;
		@(posedge clk);
		sc_drv <= '0;
		@(negedge clk);
		chk("bcast_last", 32'h1, 32'(lnk.last_transfer));
		repeat (4) @(posedge clk);
		// Error reporting
		pulse_tmo;
		int_is(1'b0, 4);
		@(posedge clk);
		owner <= 1'b1;
		pulse_tmo;
		wait_int(1'b1);
		axi_rd(REG_ERROR, 32'h0000_0008, RESP_OKAY);
		axi_rd(REG_STATUS, 32'h0000_0010, RESP_OKAY);
		@(posedge clk);
		bus_err <= 1'b1;
		@(posedge clk);
		bus_err <= 1'b0;
		axi_wr(REG_ERR_CLR, 32'h0, RESP_OKAY);
		wait_int(1'b0);
		wait_int(1'b1);
		axi_rd(REG_ERROR, 32'h0000_0010, RESP_OKAY);
		axi_wr(REG_ERR_CLR, 32'h0, RESP_OKAY);
		int_is(1'b0, 6);
		@(posedge clk);
		sc_drv <= 10'h06d;
		@(posedge clk);
		sc_drv <= '0;
		tmo <= 1'b1;
		@(posedge clk);
		tmo <= 1'b0;
		int_is(1'b0, 4);
		@(posedge clk);
		sc_drv <= 10'h01c;
		@(posedge clk);
		sc_drv <= '0;
		repeat (2) @(posedge clk);
		pulse_tmo;
		wait_int(1'b1);
		axi_wr(REG_ERR_CLR, 32'h0, RESP_OKAY);
		int_is(1'b0, 4);
		print_verdict;
	end
endmodule
